// ==== design/data_address_generator.sv ====
/*
  Data address generator: forms the data-space address of each operand
  access from the instruction word, the bank pointer and three pointer
  pairs, applies pointer side effects and serves the pointer registers.
  Assumes a data RAM with one cycle of read latency behind ram_cmd_q and
  a decoder that issues at most one request per cycle.
*/
`include "dag_cfg.svh"
module data_address_generator (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Access request from the instruction decoder
  input  wire logic              req_valid,
  input  wire dag_pkg::req_t     req,
  input  wire logic [7:0]        acc_value,
  input  wire logic [3:0]        bank_pointer,
  input  wire logic              extended_instruction_enable,
  // Data RAM and register space
  output dag_pkg::ram_cmd_t      ram_cmd_q,
  input  wire logic [7:0]        ram_rdata,
  // Answers to the decoder
  output logic                   rsp_valid_q,
  output logic [7:0]             rsp_data_q,
  output logic                   acc_we_q,
  output logic [7:0]             acc_wdata_q,
  output logic [5:0]             op_field_q
);

  localparam int PAIRS = 3;

  // Reset release
  logic                  rst_meta_q;
  logic                  rst_n_q;

  // Instruction fields
  logic [7:0]            file_addr;
  logic                  access_bit;
  logic                  dest_bit;
  logic [5:0]            op_field;

  // Address formation
  logic [`ADDR_W-1:0]    ptr_val [PAIRS];
  logic [`ADDR_W-1:0]    direct_addr;
  logic [`ADDR_W-1:0]    sel_ptr;
  logic [`ADDR_W-1:0]    acc_ext;
  logic [`ADDR_W-1:0]    eff_addr;
  dag_pkg::hit_t         hit_dir;
  dag_pkg::hit_t         hit_eff;

  // Access actions
  logic                  to_acc;
  logic                  mem_rd;
  logic                  mem_wr;
  logic                  null_target;
  logic                  local_target;
  logic                  wr_ptr_byte;
  logic                  step_any;
  logic                  step_up;
  logic                  step_kept;
  logic                  ram_go;
  logic [7:0]            local_data;
  logic [PAIRS-1:0]      wr_hi;
  logic [PAIRS-1:0]      wr_lo;
  logic [PAIRS-1:0]      step_en;

  // Read return pipeline
  dag_pkg::rdsrc_t       s1_src_q;
  logic [7:0]            s1_data_q;
  dag_pkg::rdsrc_t       s2_src_q;
  logic [7:0]            s2_data_q;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Byte-oriented layout: operation, destination, access, file address
  assign op_field   = req.opcode[`OPC_OP_HI:`OPC_OP_LO];        // see RULE21
  assign dest_bit   = req.opcode[`OPC_DEST];                    // see RULE21
  assign access_bit = req.opcode[`OPC_ACCESS];                  // see RULE21
  assign file_addr  = req.opcode[`OPC_FILE_HI:`OPC_FILE_LO];    // see RULE21

  function automatic logic [`ADDR_W-1:0] pair_base(input logic [1:0] n);
    logic [`ADDR_W-1:0] b;
    case (n)
      2'h0:    b = `PAIR0_BASE;
      2'h1:    b = `PAIR1_BASE;
      default: b = `PAIR2_BASE;
    endcase
    return b;
  endfunction

  // Finds which pointer operand or pointer byte an address names
  function automatic dag_pkg::hit_t classify(input logic [`ADDR_W-1:0] addr);
    dag_pkg::hit_t      h;
    logic [`ADDR_W-1:0] b;
    h      = '0;
    h.kind = dag_pkg::OP_NONE;
    for (int n = 0; n < PAIRS; n++) begin
      b = pair_base(n[1:0]);
      if (addr == b - `OFS_PLAIN) begin
        h.virt = 1'b1;
        h.kind = dag_pkg::OP_PLAIN;
        h.pair = n[1:0];
      end else if (addr == b - `OFS_AFTER_ACCESS_INCREMENT_OPERAND) begin
        h.virt = 1'b1;
        h.kind = dag_pkg::OP_AFTER_ACCESS_INCREMENT_OPERAND;
        h.pair = n[1:0];
      end else if (addr == b - `OFS_AFTER_ACCESS_DECREMENT_OPERAND) begin
        h.virt = 1'b1;
        h.kind = dag_pkg::OP_AFTER_ACCESS_DECREMENT_OPERAND;
        h.pair = n[1:0];
      end else if (addr == b - `OFS_BEFORE_ACCESS_INCREMENT_OPERAND) begin
        h.virt = 1'b1;
        h.kind = dag_pkg::OP_BEFORE_ACCESS_INCREMENT_OPERAND;
        h.pair = n[1:0];
      end else if (addr == b - `OFS_ACCUMULATOR_OFFSET_OPERAND) begin
        h.virt = 1'b1;
        h.kind = dag_pkg::OP_ACCUMULATOR_OFFSET_OPERAND;
        h.pair = n[1:0];
      end else if (addr == b - `OFS_PTR_HI) begin
        h.pbyte = 1'b1;
        h.phigh = 1'b1;
        h.bpair = n[1:0];
      end else if (addr == b - `OFS_PTR_LO) begin
        h.pbyte = 1'b1;
        h.phigh = 1'b0;
        h.bpair = n[1:0];
      end
    end
    return h;
  endfunction

  // Operand address as the instruction names it
  always_comb begin
    if (access_bit) begin
      // Bank addressing is never remapped (see RULE17, RULE20, RULE22)
      direct_addr = {bank_pointer, file_addr};
    end else if (extended_instruction_enable && (file_addr <= `FILE_INDEX_MAX)) begin
      // Window over the third pointer; the sum wraps (see RULE15, RULE19, RULE24)
      direct_addr = ptr_val[`INDEX_PAIR] + {`ZERO_NIBBLE, file_addr};
    end else if (file_addr > `FILE_INDEX_MAX) begin
      // Upper access area sits at the top of bank 15 (see RULE16, RULE22)
      direct_addr = {`PAGE_ACCESS_HI, file_addr};
    end else begin
      // Lower access area in bank 0 while the extended set is off (see RULE14)
      direct_addr = {`PAGE_ACCESS_LO, file_addr};
    end
  end

  assign hit_dir = classify(direct_addr);
  assign sel_ptr = ptr_val[hit_dir.pair];
  assign acc_ext = {{4{acc_value[7]}}, acc_value};

  // Indirect target: the pointer, with the accumulator for the offset operand, decides it; bank and access bit play
  // no part once a pointer operand is named (see RULE3)
  always_comb begin
    case (hit_dir.kind)
      dag_pkg::OP_PLAIN:   eff_addr = sel_ptr;                  // see RULE2
      dag_pkg::OP_AFTER_ACCESS_INCREMENT_OPERAND: eff_addr = sel_ptr;                  // see RULE5
      dag_pkg::OP_AFTER_ACCESS_DECREMENT_OPERAND: eff_addr = sel_ptr;                  // see RULE4
      dag_pkg::OP_BEFORE_ACCESS_INCREMENT_OPERAND:  eff_addr = sel_ptr + `PTR_STEP;      // see RULE6
      dag_pkg::OP_ACCUMULATOR_OFFSET_OPERAND:   eff_addr = sel_ptr + acc_ext;        // see RULE7 RULE24
      default:             eff_addr = direct_addr;
    endcase
  end

  assign hit_eff = classify(eff_addr);

  // A pointer aimed at a pointer operand reaches nothing
  assign null_target  = hit_dir.virt && hit_eff.virt;           // see RULE10 RULE11
  // Pointer bytes live here, by direct or indirect access (see RULE13)
  assign local_target = hit_eff.pbyte;

  // Destination 0 sends the result to the accumulator, not to memory
  assign to_acc = req_valid && req.write && !dest_bit;          // see RULE23
  assign mem_wr = req_valid && req.write && dest_bit;           // see RULE23
  assign mem_rd = req_valid && !req.write;

  assign wr_ptr_byte = mem_wr && local_target;
  assign ram_go      = (mem_rd || mem_wr) && !local_target && !null_target;

  // Side effects apply once per instruction, on the committing access unless it writes the accumulator
  assign step_any = req_valid && req.commit && !to_acc &&
                    ((hit_dir.kind == dag_pkg::OP_AFTER_ACCESS_INCREMENT_OPERAND) ||
                     (hit_dir.kind == dag_pkg::OP_AFTER_ACCESS_DECREMENT_OPERAND) ||
                     (hit_dir.kind == dag_pkg::OP_BEFORE_ACCESS_INCREMENT_OPERAND));
  assign step_up  = (hit_dir.kind != dag_pkg::OP_AFTER_ACCESS_DECREMENT_OPERAND);
  // Writing a pair through its own operand drops the step (see RULE12)
  assign step_kept = step_any && !(wr_ptr_byte && (hit_eff.bpair == hit_dir.pair));

  // Pointer byte read; the unused upper nibble reads as zero (see RULE1)
  assign local_data = hit_eff.phigh ?
                      {`ZERO_NIBBLE, ptr_val[hit_eff.bpair][`ADDR_W-1:8]} :
                      ptr_val[hit_eff.bpair][7:0];

  // Pointer pairs; steps never reach any status flag (see RULE9)
  for (genvar n = 0; n < PAIRS; n++) begin : g_pair
    assign wr_hi[n]   = wr_ptr_byte && (hit_eff.bpair == 2'(n)) && hit_eff.phigh;
    assign wr_lo[n]   = wr_ptr_byte && (hit_eff.bpair == 2'(n)) && !hit_eff.phigh;
    assign step_en[n] = step_kept && (hit_dir.pair == 2'(n));   // see RULE4 RULE5 RULE6

    pointer_pair u_pair (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_q),
      .wr_hi   (wr_hi[n]),
      .wr_lo   (wr_lo[n]),
      .wdata   (req.wdata),
      .step_en (step_en[n]),
      .step_up (step_up),
      .value_q (ptr_val[n])                                     // see RULE1
    );
  end

  // Command to the data RAM and register space
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ram_cmd_q <= '0;
    end else begin
      ram_cmd_q.re    <= ram_go && mem_rd;
      // Null targets and pointer bytes never reach the RAM (see RULE11)
      ram_cmd_q.we    <= ram_go && mem_wr;
      ram_cmd_q.addr  <= ram_go ? eff_addr : ram_cmd_q.addr;
      ram_cmd_q.wdata <= (ram_go && mem_wr) ? req.wdata : ram_cmd_q.wdata;
    end
  end

  // Source of the read answer, first stage
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_src_q  <= dag_pkg::RD_NONE;
      s1_data_q <= `ZERO_BYTE;
    end else if (!mem_rd) begin
      s1_src_q  <= dag_pkg::RD_NONE;
    end else if (null_target) begin
      s1_src_q  <= dag_pkg::RD_ZERO;                            // see RULE10
    end else if (local_target) begin
      s1_src_q  <= dag_pkg::RD_LOCAL;
      s1_data_q <= local_data;                                  // see RULE13
    end else begin
      s1_src_q  <= dag_pkg::RD_RAM;
    end
  end

  // Second stage, aligned with the RAM read data
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s2_src_q  <= dag_pkg::RD_NONE;
      s2_data_q <= `ZERO_BYTE;
    end else begin
      s2_src_q  <= s1_src_q;
      s2_data_q <= s1_data_q;
    end
  end

  // Read answer to the decoder
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= `ZERO_BYTE;
    end else begin
      rsp_valid_q <= (s2_src_q != dag_pkg::RD_NONE);
      case (s2_src_q)
        dag_pkg::RD_RAM:   rsp_data_q <= ram_rdata;
        dag_pkg::RD_ZERO:  rsp_data_q <= `ZERO_BYTE;            // see RULE10
        dag_pkg::RD_LOCAL: rsp_data_q <= s2_data_q;
        default:           rsp_data_q <= rsp_data_q;
      endcase
    end
  end

  // Results with destination 0 go back to the accumulator
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_we_q    <= 1'b0;
      acc_wdata_q <= `ZERO_BYTE;
    end else begin
      acc_we_q <= to_acc;                                       // see RULE23
      if (to_acc) begin
        acc_wdata_q <= req.wdata;
      end
    end
  end

  // Operation field handed back with each accepted request
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      op_field_q <= '0;
    end else if (req_valid) begin
      op_field_q <= op_field;                                   // see RULE21
    end
  end

  // Inherent and literal instructions never issue a request here, so the
  // extended set cannot alter them (see RULE18)

endmodule

// ==== design/dag_cfg.svh ====
/*
  Constants for the data address generator: instruction field positions,
  access-area boundaries, pointer reset value and the placement of the
  pointer registers and their operand addresses in the data space.
  Assumes a 12-bit data space shared by general RAM and special registers.
*/
// Overview of operation
// RULE1: Three 12-bit pointer pairs, upper nibble unused.
// RULE2: Plain operand accesses pointer target, no change.
// RULE3: Indirect uses full pointer, ignores bank, access bit.
// RULE4: After-access decrement: use target, then pointer minus one.
// RULE5: After-access increment: use target, then pointer plus one.
// RULE6: Before-access increment: pointer plus one, then use.
// RULE7: Accumulator offset: pointer plus signed accumulator, unchanged.
// RULE8: Steps act on whole pair, carry into high.
// RULE9: Pointer steps never touch arithmetic status flags.
// RULE10: Indirect read of a virtual operand returns zero.
// RULE11: Indirect write to a virtual operand does nothing.
// RULE12: Write via own operand stores without stepping.
// RULE13: Pointers are plain registers; indirect reaches other registers.
// RULE14: Extended set keeps space, map, first two pointers.
// RULE15: Extended, access bit 0, address up to 5Fh: third pointer plus address.
// RULE16: Access bit 0, address 60h up: bank 15 top.
// RULE17: Access bit 1: bank pointer with 8-bit address.
// RULE18: Inherent and literal instructions unaffected by extended set.
// RULE19: Low 96 access locations map to third-pointer window.
// RULE20: Remapping only in indexed mode, bank addressing unchanged.
// RULE21: Opcode: 6-bit operation, destination, access, file address.
// RULE22: Direct: bank plus address, or access area.
// RULE23: Destination bit 1 to file, 0 to accumulator.
// RULE24: Pointer plus offset sums wrap to 12 bits.
`ifndef DAG_CFG_SVH
`define DAG_CFG_SVH

`define ADDR_W          12
`define OPC_OP_HI       15
`define OPC_OP_LO       10
`define OPC_DEST        9
`define OPC_ACCESS      8
`define OPC_FILE_HI     7
`define OPC_FILE_LO     0

`define FILE_INDEX_MAX  8'h5f
`define PAGE_ACCESS_HI  4'hf
`define PAGE_ACCESS_LO  4'h0
`define ZERO_NIBBLE     4'h0
`define ZERO_BYTE       8'h00
`define PTR_RESET       12'h000
`define PTR_STEP        12'h001
`define INDEX_PAIR      2'h2

`define PAIR0_BASE      12'hfef
`define PAIR1_BASE      12'hfe7
`define PAIR2_BASE      12'hfdf
`define OFS_PLAIN       12'h000
`define OFS_AFTER_ACCESS_INCREMENT_OPERAND     12'h001
`define OFS_AFTER_ACCESS_DECREMENT_OPERAND     12'h002
`define OFS_BEFORE_ACCESS_INCREMENT_OPERAND      12'h003
`define OFS_ACCUMULATOR_OFFSET_OPERAND       12'h004
`define OFS_PTR_HI      12'h005
`define OFS_PTR_LO      12'h006

`endif

// ==== design/dag_pkg.sv ====
/*
  Types shared by the data address generator, its checker, the RAM model and the bench.
  Assumes dag_cfg.svh for the address width.
*/
`include "dag_cfg.svh"
package dag_pkg;

  typedef enum logic [5:0] {
    OP_NONE    = 6'h01,
    OP_PLAIN   = 6'h02,
    OP_AFTER_ACCESS_INCREMENT_OPERAND = 6'h04,
    OP_AFTER_ACCESS_DECREMENT_OPERAND = 6'h08,
    OP_BEFORE_ACCESS_INCREMENT_OPERAND  = 6'h10,
    OP_ACCUMULATOR_OFFSET_OPERAND   = 6'h20
  } opkind_t;

  typedef enum logic [3:0] {
    RD_NONE  = 4'h1,
    RD_RAM   = 4'h2,
    RD_ZERO  = 4'h4,
    RD_LOCAL = 4'h8
  } rdsrc_t;

  typedef struct packed {
    logic        write;
    logic        commit;
    logic [15:0] opcode;
    logic [7:0]  wdata;
  } req_t;

  typedef struct packed {
    logic                re;
    logic                we;
    logic [`ADDR_W-1:0]  addr;
    logic [7:0]          wdata;
  } ram_cmd_t;

  typedef struct packed {
    logic        virt;
    opkind_t     kind;
    logic [1:0]  pair;
    logic        pbyte;
    logic        phigh;
    logic [1:0]  bpair;
  } hit_t;

endpackage

// ==== design/pointer_pair.sv ====
/*
  One 12-bit pointer pair with byte writes and whole-pair stepping.
  Assumes the caller never asks for a byte write and a step it wants
  kept in the same cycle; the byte write wins.
*/
`include "dag_cfg.svh"
module pointer_pair (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Byte writes
  input  wire logic              wr_hi,
  input  wire logic              wr_lo,
  input  wire logic [7:0]        wdata,
  // Automatic step
  input  wire logic              step_en,
  input  wire logic              step_up,
  // Current value
  output logic [`ADDR_W-1:0]     value_q
);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= `PTR_RESET;
    end else if (wr_hi || wr_lo) begin
      // Stored value is kept as written, no step applied (see RULE12)
      if (wr_hi) begin
        value_q[`ADDR_W-1:8] <= wdata[3:0];       // see RULE1
      end
      if (wr_lo) begin
        value_q[7:0] <= wdata;
      end
    end else if (step_en) begin
      // Whole-pair arithmetic so the low byte carries into the high (see RULE8)
      if (step_up) begin
        value_q <= value_q + `PTR_STEP;
      end else begin
        value_q <= value_q - `PTR_STEP;
      end
    end
  end

endmodule

// ==== verification/data_address_generator_chk.sv ====
/*
  Port checker for the data address generator: answer timing, result
  routing and direct address forming.
  Assumes binding into every data_address_generator instance.
*/
module data_address_generator_chk (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rstn,
  // Requests
  input wire logic              req_valid,
  input wire dag_pkg::req_t     req,
  input wire logic [7:0]        acc_value,
  input wire logic [3:0]        bank_pointer,
  input wire logic              extended_instruction_enable,
  // Data space
  input wire dag_pkg::ram_cmd_t ram_cmd_q,
  input wire logic [7:0]        ram_rdata,
  // Answers
  input wire logic              rsp_valid_q,
  input wire logic [7:0]        rsp_data_q,
  input wire logic              acc_we_q,
  input wire logic [7:0]        acc_wdata_q,
  input wire logic [5:0]        op_field_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_rd; req_valid && !req.write; endsequence
  sequence s_acc; req_valid && req.write && !req.opcode[9]; endsequence
  sequence s_mem; req_valid && !(req.write && !req.opcode[9]); endsequence
  sequence s_bank; s_mem ##0 req.opcode[8] && bank_pointer != 4'hf; endsequence
  sequence s_bank_rd; s_bank ##0 !req.write ##1 ram_cmd_q.re ##1 1'b1; endsequence
  a_read_latency: assert property (s_rd |-> ##3 rsp_valid_q)
    else $error("read answer not on time");
  a_write_silent: assert property (req_valid && req.write |-> ##3 !rsp_valid_q)
    else $error("write gave an answer");
  a_acc_route: assert property (s_acc |=> acc_we_q && !ram_cmd_q.we && !ram_cmd_q.re
    && acc_wdata_q == $past(req.wdata)) else $error("accumulator result misrouted");
  a_file_route: assert property (s_mem |=> !acc_we_q)
    else $error("accumulator written for file result");
  a_bank_addr: assert property (s_bank |=> (ram_cmd_q.re || ram_cmd_q.we)
    && ram_cmd_q.addr == {$past(bank_pointer), $past(req.opcode[7:0])})
    else $error("bank address wrong");
  a_access_top: assert property (s_mem ##0 !req.opcode[8]
    && req.opcode[7:0] inside {[8'h60:8'hd8]} |=> (ram_cmd_q.re || ram_cmd_q.we)
    && ram_cmd_q.addr == {4'hf, $past(req.opcode[7:0])}) else $error("access top wrong");
  a_access_low: assert property (s_mem ##0 !req.opcode[8] && req.opcode[7:0] <= 8'h5f
    && !extended_instruction_enable |=> ram_cmd_q.addr == {4'h0, $past(req.opcode[7:0])})
    else $error("access low wrong");
  a_op_field: assert property (req_valid |=> op_field_q == $past(req.opcode[15:10]))
    else $error("op field wrong");
  a_ram_data: assert property (s_bank_rd |=> rsp_valid_q && rsp_data_q == $past(ram_rdata))
    else $error("read data not passed on");
  a_write_data: assert property (s_bank ##0 req.write |=> ram_cmd_q.we
    && ram_cmd_q.wdata == $past(req.wdata)) else $error("file write data wrong");
  a_idle_quiet: assert property (!req_valid |=> !ram_cmd_q.re && !ram_cmd_q.we && !acc_we_q)
    else $error("activity without request");
endmodule

bind data_address_generator data_address_generator_chk data_address_generator_chk_i (
  .clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid), .req(req), .acc_value(acc_value),
  .bank_pointer(bank_pointer), .extended_instruction_enable(extended_instruction_enable),
  .ram_cmd_q(ram_cmd_q), .ram_rdata(ram_rdata), .rsp_valid_q(rsp_valid_q),
  .rsp_data_q(rsp_data_q), .acc_we_q(acc_we_q), .acc_wdata_q(acc_wdata_q),
  .op_field_q(op_field_q));

// ==== verification/ram_model.sv ====
/*
  Data RAM and register space behind the address generator.
  Assumes one command per cycle; read data follows one cycle later.
*/
module ram_model (
  // Clock
  input  wire logic              clk_sys,
  // Command in, read data out
  input  wire dag_pkg::ram_cmd_t ram_cmd,
  output logic [7:0]             ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [4096];
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'(i >> 4) ^ 8'h5c;
    ram_rdata = 8'h00;
  end
  // Outside the valid cycle the lines toggle so a late sample cannot match
  always @(posedge clk_sys) begin
    if (ram_cmd.we) mem[ram_cmd.addr] <= ram_cmd.wdata;
    ram_rdata <= ram_cmd.re ? mem[ram_cmd.addr] : ~ram_rdata;
  end
endmodule

// ==== verification/tb_data_address_generator.sv ====
/*
  Bench for the data address generator: pointer loads, every operand kind,
  virtual targets, extended mode and a random back-to-back mix.
  Assumes ram_model as the data space.
*/
`include "dag_cfg.svh"
module tb_data_address_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys;
  logic              rstn;
  logic              req_valid;
  dag_pkg::req_t     req;
  logic [7:0]        acc_value;
  logic [3:0]        bank_pointer;
  logic              extended_instruction_enable;
  dag_pkg::ram_cmd_t ram_cmd_q;
  logic [7:0]        ram_rdata;
  logic              rsp_valid_q;
  logic [7:0]        rsp_data_q;
  logic              acc_we_q;
  logic [7:0]        acc_wdata_q;
  logic [5:0]        op_field_q;
  logic [11:0]       ptr [3];
  logic [7:0]        sh [4096];
  int                n_errors;
  int                cmp_count;
  localparam logic [11:0] BASE [3] = '{`PAIR0_BASE, `PAIR1_BASE, `PAIR2_BASE};

  data_address_generator data_address_generator_i (.clk_sys(clk_sys), .rstn(rstn),
    .req_valid(req_valid), .req(req), .acc_value(acc_value), .bank_pointer(bank_pointer),
    .extended_instruction_enable(extended_instruction_enable), .ram_cmd_q(ram_cmd_q),
    .ram_rdata(ram_rdata), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .acc_we_q(acc_we_q), .acc_wdata_q(acc_wdata_q), .op_field_q(op_field_q));
  ram_model ram_model_i (.clk_sys(clk_sys), .ram_cmd(ram_cmd_q), .ram_rdata(ram_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Pair whose register block holds x, with x's distance below its base
  function automatic int pair_of(input logic [11:0] x, output logic [11:0] o);
    for (int n = 0; n < 3; n++) begin
      o = BASE[n] - x;
      if (o <= 12'h006) return n;
    end
    return -1;
  endfunction

  function automatic logic [11:0] direct(input logic a, input logic [7:0] f);
    if (a) return {bank_pointer, f};
    if (f > 8'h5f) return {4'hf, f};
    return extended_instruction_enable ? ptr[2] + {4'h0, f} : {4'h0, f};
  endfunction

  task automatic check(input logic wr, d, mem, input logic [11:0] t, input logic [7:0] exp,
                       input logic [5:0] fld, input logic [7:0] wd);
    @(posedge clk_sys);
    #1;
    chk("ram_re", ram_cmd_q.re, mem && !wr);
    chk("ram_we", ram_cmd_q.we, mem && wr);
    if (mem) chk("ram_addr", ram_cmd_q.addr, t);
    if (mem && wr) chk("ram_wdata", ram_cmd_q.wdata, wd);
    chk("acc_we", acc_we_q, wr && !d);
    if (wr && !d) chk("acc_wdata", acc_wdata_q, wd);
    chk("op_field", op_field_q, fld);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("rsp_valid", rsp_valid_q, !wr);
    if (!wr) chk("rsp_data", rsp_data_q, exp);
  endtask

  task automatic op(input logic wr, d, a, input logic [7:0] f, input logic [7:0] wd);
    logic [11:0] t;
    logic [11:0] o;
    logic [11:0] o2;
    logic [5:0]  fld;
    logic [7:0]  exp;
    logic        mem;
    int          n;
    logic [11:0] p0;
    int          n2;
    @(posedge clk_sys);
    fld = 6'($urandom);
    req_valid <= 1'b1;
    req <= '{wr, 1'b1, {fld, d, a, f}, wd};
    t = direct(a, f);
    n = pair_of(t, o);
    mem = !(wr && !d);
    exp = sh[t];
    if (mem && n >= 0 && o > 12'h004) begin
      mem = 1'b0;
      exp = o == 12'h005 ? {4'h0, ptr[n][11:8]} : ptr[n][7:0];
      if (wr) ptr[n] = o == 12'h005 ? {wd[3:0], ptr[n][7:0]} : {ptr[n][11:8], wd};
    end else if (mem && n >= 0) begin
      p0 = ptr[n];
      t = ptr[n] + (o == 12'h003 ? 12'h001 :
                    o == 12'h004 ? {{4{acc_value[7]}}, acc_value} : 12'h000);
      ptr[n] = ptr[n] + (o == 12'h001 || o == 12'h003 ? 12'h001 :
                         o == 12'h002 ? 12'hfff : 12'h000);
      exp = sh[t];
      n2 = pair_of(t, o2);
      if (n2 >= 0) begin
        mem = 1'b0;
        exp = 8'h00;
        if (o2 > 12'h004) begin
          // Pointer byte as target: old value reads back, own-pair write drops the step
          if (n2 != n) p0 = ptr[n2];
          exp = o2 == 12'h005 ? {4'h0, p0[11:8]} : p0[7:0];
          if (wr) ptr[n2] = o2 == 12'h005 ? {wd[3:0], p0[7:0]} : {p0[11:8], wd};
        end
      end
    end
    if (mem && wr) sh[t] = wd;
    fork
      check(wr, d, mem, t, exp, fld, wd);
    join_none
  endtask

  task automatic ind(input logic wr, input int n, input int k, input logic [7:0] wd);
    op(wr, 1'b1, 1'b0, BASE[n][7:0] - 8'(k), wd);
  endtask

  task automatic load(input int n, input logic [11:0] v);
    op(1'b1, 1'b1, 1'b0, BASE[n][7:0] - 8'h05, {4'ha, v[11:8]});
    op(1'b1, 1'b1, 1'b0, BASE[n][7:0] - 8'h06, v[7:0]);
  endtask

  task automatic cfg(input logic [7:0] acc, input logic [3:0] bank, input logic ext);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    acc_value <= acc;
    bank_pointer <= bank;
    extended_instruction_enable <= ext;
  endtask

  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end

  initial begin
    logic [31:0] x;
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    acc_value = 8'h00;
    bank_pointer = 4'h0;
    extended_instruction_enable = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    foreach (ptr[i]) ptr[i] = 12'h000;
    for (int i = 0; i < 4096; i++) sh[i] = 8'(i) ^ 8'(i >> 4) ^ 8'h5c;
    void'($urandom(32'h5e3b5a87));
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int n = 0; n < 3; n++) begin
      load(n, 12'h1ff + 12'(n) * 12'h300);
      op(1'b0, 1'b1, 1'b0, BASE[n][7:0] - 8'h05, 8'h00);
      op(1'b0, 1'b1, 1'b0, BASE[n][7:0] - 8'h06, 8'h00);
      for (int k = 0; k < 5; k++) ind(1'b0, n, k, 8'h00);
      ind(1'b1, n, 2, 8'h5a);
      ind(1'b0, n, 3, 8'h00);
      cfg(8'h80, 4'h0, 1'b0);
      ind(1'b0, n, 4, 8'h00);
      cfg(8'h7f, 4'h0, 1'b0);
      ind(1'b0, n, 4, 8'h00);
    end
    load(0, 12'hfa0);
    ind(1'b0, 0, 4, 8'h00);
    load(0, 12'hfe7);
    ind(1'b0, 0, 0, 8'h00);
    ind(1'b1, 0, 1, 8'h33);
    load(1, 12'hfe1);
    ind(1'b1, 1, 2, 8'h42);
    op(1'b0, 1'b1, 1'b0, 8'he1, 8'h00);
    load(2, 12'hfd9);
    ind(1'b0, 2, 1, 8'h00);
    ind(1'b1, 2, 0, 8'h05);
    load(0, 12'hfd9);
    ind(1'b1, 0, 1, 8'h3c);
    ind(1'b0, 0, 0, 8'h00);
    load(0, 12'h300);
    load(1, 12'h600);
    load(2, 12'h900);
    for (int e = 0; e < 2; e++) begin
      cfg(8'h00, 4'h3, e[0]);
      op(1'b0, 1'b1, 1'b1, 8'h20, 8'h00);
      op(1'b0, 1'b1, 1'b0, 8'h5f, 8'h00);
      op(1'b0, 1'b1, 1'b0, 8'h60, 8'h00);
      op(1'b1, 1'b0, 1'b0, 8'h10, 8'h77);
      op(1'b1, 1'b1, 1'b0, 8'h00, 8'h99);
      op(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    end
    repeat (400) begin
      x = $urandom;
      if (x[5:2] == 4'h0) cfg(x[31:24], 4'(x[23:20] % 4'hf), x[19]);
      else if (x[5:2] == 4'hf) cfg(acc_value, bank_pointer, extended_instruction_enable);
      else if (x[5:2] < 4'h6) op(x[6], x[7], 1'b0,
        BASE[x[9:8] % 3][7:0] - 8'(x[12:10] % 5), x[31:24]);
      else op(x[6], x[7], x[13], x[13] ? x[23:16] : x[14] ? 8'(x[23:16] % 8'h60) :
        8'h60 + 8'(x[23:16] % 8'h79), x[31:24]);
    end
    cfg(acc_value, bank_pointer, extended_instruction_enable);
    repeat (6) @(posedge clk_sys);
    end_of_test();
  end
endmodule
